//--- hdl/rtcf_event_status.sv
// Event flags, interrupt request and backup integrity status behind the multiplexed bus.
`timescale 1ns/100ps
`default_nettype none
`include "rtcf_cfg.svh"

module rtcf_event_status #(
  parameter int unsigned AD_WIDTH = 8
) (
  input  wire logic                REF_CLK_IN,             // 200 MHz block clock.
  input  wire logic                RST_IN,                 // Asynchronous reset, active high.
  input  wire logic [AD_WIDTH-1:0] AD_IN,                  // Address/data pins, input side.
  output logic      [AD_WIDTH-1:0] AD_OUT,                 // Address/data pins, read data.
  output logic                     AD_OE_OUT,              // High while the block drives the data pins.
  input  wire logic                AS_IN,                  // Address strobe; address taken on its fall.
  input  wire logic                DS_IN,                  // Data strobe; high during data phase.
  input  wire logic                RW_IN,                  // High for read, low for write.
  input  wire logic                CS_N_IN,                // Chip select, active low.
  input  wire logic                BACKUP_VALID_IN,        // Backup source good level, asynchronous.
  input  wire logic                UPDATE_DONE_IN,         // One-cycle pulse at end of update cycle.
  input  wire logic                ALARM_HIT_IN,           // One-cycle pulse on alarm match.
  input  wire logic                PERIODIC_TICK_IN,       // One-cycle pulse per periodic interval.
  input  wire logic                ALARM_IRQ_ENABLE_IN,    // Alarm interrupt enable.
  input  wire logic                PERIODIC_IRQ_ENABLE_IN, // Periodic interrupt enable.
  input  wire logic                UPDATE_IRQ_ENABLE_IN,   // Update-ended interrupt enable as written.
  input  wire logic                TRANSFER_INHIBIT_IN,    // Update transfer inhibit bit.
  output logic                     UPDATE_IRQ_ENABLE_OUT,  // Effective update enable after inhibit.
  output logic                     IRQ_N_OUT               // Interrupt request, active low.
);

  localparam int unsigned SYNC_W = AD_WIDTH + 5;

  generate
    if (AD_WIDTH != 8) begin : g_bad_width
      $error("rtcf_event_status serves an eight-bit bus only");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  logic [SYNC_W-1:0]   sync_s;
  logic [AD_WIDTH-1:0] ad_s;
  logic                as_s;
  logic                ds_s;
  logic                rw_s;
  logic                cs_n_s;
  logic                valid_s;

  rtcf_sync2 #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_in (REF_CLK_IN),
    .rst_in (RST_IN),
    .d_in   ({BACKUP_VALID_IN, CS_N_IN, RW_IN, DS_IN, AS_IN, AD_IN}),
    .q_out  (sync_s)
  );

  // All bus pins share one synchroniser delay, so address stays aligned with the strobes.
  always_comb begin
    ad_s    = sync_s[AD_WIDTH-1:0];
    as_s    = sync_s[AD_WIDTH];
    ds_s    = sync_s[AD_WIDTH+1];
    rw_s    = sync_s[AD_WIDTH+2];
    cs_n_s  = sync_s[AD_WIDTH+3];
    valid_s = sync_s[AD_WIDTH+4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic rtcf_pkg::rtcf_sel_type decode_sel(input logic [AD_WIDTH-1:0] addr);
    if (addr == `RTCF_ADDR_EVENT) begin
      decode_sel = rtcf_pkg::RTCF_SEL_EVENT;
    end else if (addr == `RTCF_ADDR_BACKUP) begin
      decode_sel = rtcf_pkg::RTCF_SEL_BACKUP;
    end else begin
      decode_sel = rtcf_pkg::RTCF_SEL_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic                  as_prev_q;
  logic                  as_prev_d;
  logic                  ds_prev_q;
  logic                  ds_prev_d;
  rtcf_pkg::rtcf_sel_type sel_q;
  rtcf_pkg::rtcf_sel_type sel_d;
  rtcf_pkg::rtcf_byte_type rd_data_q;
  rtcf_pkg::rtcf_byte_type rd_data_d;
  logic                  drive_q;
  logic                  drive_d;
  logic                  clear_pend_q;
  logic                  clear_pend_d;
  logic                  update_flag_q;
  logic                  update_flag_d;
  logic                  alarm_flag_q;
  logic                  alarm_flag_d;
  logic                  periodic_flag_q;
  logic                  periodic_flag_d;
  logic                  irq_flag_q;
  logic                  irq_flag_d;

  logic                  as_fall;
  logic                  ds_rise;
  logic                  ds_fall;
  logic                  read_cycle;
  logic                  clear_now;
  logic                  update_en_eff;
  rtcf_pkg::rtcf_byte_type event_byte;
  rtcf_pkg::rtcf_byte_type backup_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    as_fall    = as_prev_q & ~as_s;
    ds_rise    = ~ds_prev_q & ds_s;
    ds_fall    = ds_prev_q & ~ds_s;
    read_cycle = ~cs_n_s & rw_s;

    as_prev_d = as_s;
    ds_prev_d = ds_s;

    update_en_eff = UPDATE_IRQ_ENABLE_IN & ~TRANSFER_INHIBIT_IN;

    event_byte                     = `RTCF_BYTE_ZERO;
    event_byte[`RTCF_BIT_IRQ]      = irq_flag_q;
    event_byte[`RTCF_BIT_PERIODIC] = periodic_flag_q;
    event_byte[`RTCF_BIT_ALARM]    = alarm_flag_q;
    event_byte[`RTCF_BIT_UPDATE]   = update_flag_q;

    backup_byte = `RTCF_BYTE_ZERO;
    backup_byte[`RTCF_BIT_VALID] = valid_s;

    // Address phase: a new address replaces any earlier one.
    sel_d = sel_q;
    if (as_fall && !cs_n_s) begin
      sel_d = decode_sel(ad_s);
    end

    rd_data_d    = rd_data_q;
    drive_d      = drive_q;
    clear_pend_d = clear_pend_q;
    if (ds_rise && read_cycle) begin
      case (sel_q)
        rtcf_pkg::RTCF_SEL_EVENT: begin
          rd_data_d    = event_byte;
          drive_d      = 1'h1;
          clear_pend_d = 1'h1;
        end
        rtcf_pkg::RTCF_SEL_BACKUP: begin
          rd_data_d = backup_byte;
          drive_d   = 1'h1;
        end
        default: begin
          drive_d = 1'h0;
        end
      endcase
    end else if (ds_fall || cs_n_s) begin
      drive_d      = 1'h0;
      clear_pend_d = 1'h0;
    end

    // Clear after data returned.
    // The clear waits for the strobe to fall, so the host has already sampled the byte.
    clear_now = ds_fall & clear_pend_q;

    // An event in the clearing cycle wins over the clear, so none is lost.
    // Update-ended sets flag.
    update_flag_d   = (update_flag_q & ~clear_now) | UPDATE_DONE_IN;
    alarm_flag_d    = (alarm_flag_q & ~clear_now) | ALARM_HIT_IN;
    periodic_flag_d = (periodic_flag_q & ~clear_now) | PERIODIC_TICK_IN;

    irq_flag_d = (irq_flag_q & ~clear_now)
               | (update_flag_d & update_en_eff)
               | (alarm_flag_d & ALARM_IRQ_ENABLE_IN)
               | (periodic_flag_d & PERIODIC_IRQ_ENABLE_IN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      // Edge memory starts at the synchroniser's reset level, so no false strobe edge follows reset.
      as_prev_q       <= `RTCF_SYNC_RESET;
      ds_prev_q       <= `RTCF_FLAG_RESET;
      sel_q           <= rtcf_pkg::RTCF_SEL_NONE;
      rd_data_q       <= `RTCF_BYTE_ZERO;
      drive_q         <= `RTCF_FLAG_RESET;
      clear_pend_q    <= `RTCF_FLAG_RESET;
      update_flag_q   <= `RTCF_FLAG_RESET;
      alarm_flag_q    <= `RTCF_FLAG_RESET;
      periodic_flag_q <= `RTCF_FLAG_RESET;
      irq_flag_q      <= `RTCF_FLAG_RESET;
    end else begin
      as_prev_q       <= as_prev_d;
      ds_prev_q       <= ds_prev_d;
      sel_q           <= sel_d;
      rd_data_q       <= rd_data_d;
      drive_q         <= drive_d;
      clear_pend_q    <= clear_pend_d;
      update_flag_q   <= update_flag_d;
      alarm_flag_q    <= alarm_flag_d;
      periodic_flag_q <= periodic_flag_d;
      irq_flag_q      <= irq_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The data pins are released once the data strobe falls or select goes away, to avoid a bus fight.
  always_comb begin
    AD_OUT                = rd_data_q;
    AD_OE_OUT             = drive_q;
    UPDATE_IRQ_ENABLE_OUT = update_en_eff;
    IRQ_N_OUT = ~irq_flag_q;
  end

endmodule // rtcf_event_status

`default_nettype wire

//--- hdl/rtcf_cfg.svh
// Constants for the RTC event status and backup integrity block.
// Behaviour
// - Event status low four bits read zero.
// - Update-ended flag sets on each update completion.
// - Alarm flag sets on each alarm match.
// - Periodic flag sets once per periodic interval.
// - Interrupt flag sets when enabled flag set.
// - Reading event status clears all four flags.
// - Integrity status bits zero to six read zero.
// - Integrity bit seven reports backup source valid.
// - Event status writes change no flag.
// - Transfer inhibit forces update enable to zero.
`ifndef RTCF_CFG_SVH
`define RTCF_CFG_SVH

`define RTCF_ADDR_EVENT   8'h0c
`define RTCF_ADDR_BACKUP  8'h0d

`define RTCF_BIT_IRQ      7
`define RTCF_BIT_PERIODIC 6
`define RTCF_BIT_ALARM    5
`define RTCF_BIT_UPDATE   4
`define RTCF_BIT_VALID    7

`define RTCF_BYTE_ZERO    8'h00
`define RTCF_FLAG_RESET   1'h0
`define RTCF_SYNC_RESET   1'h0

`endif

//--- hdl/rtcf_pkg.sv
// Types shared by the RTC event status block.
package rtcf_pkg;

  // Which status register the latched bus address selects.
  typedef enum logic [1:0] {
    RTCF_SEL_NONE,
    RTCF_SEL_EVENT,
    RTCF_SEL_BACKUP
  } rtcf_sel_type;

  typedef logic [7:0] rtcf_byte_type;

endpackage

//--- hdl/rtcf_sync2.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
`timescale 1ns/100ps
`default_nettype none
`include "rtcf_cfg.svh"

module rtcf_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,  // Block clock.
  input  wire logic             rst_in,  // Asynchronous reset, active high.
  input  wire logic [WIDTH-1:0] d_in,    // Asynchronous levels.
  output logic      [WIDTH-1:0] q_out    // Synchronised levels.
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] q_d;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("rtcf_sync2 needs a width of at least one");
    end
  endgenerate

  // The first stage feeds the second stage only.
  always_comb begin
    meta_d = d_in;
    q_d    = meta_q;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= {WIDTH{`RTCF_SYNC_RESET}};
      q_out  <= {WIDTH{`RTCF_SYNC_RESET}};
    end else begin
      meta_q <= meta_d;
      q_out  <= q_d;
    end
  end

endmodule // rtcf_sync2

`default_nettype wire

//--- dv/rtcf_event_status_monitor.sv
// Checker watching the ports of the event status block.
`timescale 1ns/100ps
`default_nettype none
module rtcf_event_status_monitor #(
  parameter int unsigned AD_WIDTH = 8
) (
  input wire logic                REF_CLK_IN,
  input wire logic                RST_IN,
  input wire logic [AD_WIDTH-1:0] AD_IN,
  input wire logic [AD_WIDTH-1:0] AD_OUT,
  input wire logic                AD_OE_OUT,
  input wire logic                AS_IN,
  input wire logic                DS_IN,
  input wire logic                RW_IN,
  input wire logic                CS_N_IN,
  input wire logic                BACKUP_VALID_IN,
  input wire logic                UPDATE_DONE_IN,
  input wire logic                ALARM_HIT_IN,
  input wire logic                PERIODIC_TICK_IN,
  input wire logic                ALARM_IRQ_ENABLE_IN,
  input wire logic                PERIODIC_IRQ_ENABLE_IN,
  input wire logic                UPDATE_IRQ_ENABLE_IN,
  input wire logic                TRANSFER_INHIBIT_IN,
  input wire logic                UPDATE_IRQ_ENABLE_OUT,
  input wire logic                IRQ_N_OUT
);
  logic ev_any;
  assign ev_any = UPDATE_DONE_IN | ALARM_HIT_IN | PERIODIC_TICK_IN;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////////////////////////////////////////////
  a_low_nibble_zero: assert property ($rose(AD_OE_OUT) |-> AD_OUT[3:0] == 4'h0)
    else $error("read byte has low bits set");
  a_update_sets_irq: assert property (UPDATE_DONE_IN && UPDATE_IRQ_ENABLE_OUT |=> !IRQ_N_OUT)
    else $error("update event did not raise the request");
  a_alarm_sets_irq: assert property (ALARM_HIT_IN && ALARM_IRQ_ENABLE_IN |=> !IRQ_N_OUT)
    else $error("alarm event did not raise the request");
  a_tick_sets_irq: assert property (PERIODIC_TICK_IN && PERIODIC_IRQ_ENABLE_IN |=> !IRQ_N_OUT)
    else $error("periodic event did not raise the request");
  a_inhibit_masks_update: assert property (UPDATE_IRQ_ENABLE_OUT == (UPDATE_IRQ_ENABLE_IN && !TRANSFER_INHIBIT_IN))
    else $error("effective update enable wrong");
  a_irq_holds_unread: assert property (!IRQ_N_OUT && !AD_OE_OUT |=> !IRQ_N_OUT)
    else $error("request dropped without a read");
  a_read_clears_irq: assert property ($fell(AD_OE_OUT) && AD_OUT[6:4] != 3'h0 && !$past(ev_any) |-> IRQ_N_OUT)
    else $error("event status read left the request set");
  a_drive_only_read: assert property ($rose(AD_OE_OUT) |-> RW_IN && DS_IN && !CS_N_IN)
    else $error("data pins driven outside a read");
  c_irq_released: cover property (!IRQ_N_OUT ##1 IRQ_N_OUT);
  c_read_done: cover property ($fell(AD_OE_OUT));
  c_inhibit_on: cover property (TRANSFER_INHIBIT_IN && UPDATE_IRQ_ENABLE_IN);
endmodule // rtcf_event_status_monitor
bind rtcf_event_status rtcf_event_status_monitor #(.AD_WIDTH(AD_WIDTH)) u_monitor (.*);
`default_nettype wire

//--- dv/rtcf_host_model.sv
// Host processor model running cycles on the multiplexed status bus.
`timescale 1ns/100ps
`default_nettype none
module rtcf_host_model (
  input  wire logic       clk_in,     // Block clock.
  input  wire logic [7:0] rd_data_in, // Read data from the block.
  input  wire logic       rd_oe_in,   // Block drives the data pins.
  output logic      [7:0] ad_out,     // Address/data pins.
  output logic            as_out,     // Address strobe.
  output logic            ds_out,     // Data strobe.
  output logic            rw_out,     // High for read.
  output logic            cs_n_out    // Chip select, active low.
);
  initial begin
    ad_out = 8'h00;
    as_out = 1'h0;
    ds_out = 1'h0;
    rw_out = 1'h0;
    cs_n_out = 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Host reads or writes status.
  // The address strobe is held four cycles and the data strobe six, so the block's two-flop synchroniser always sees them.
  // On a read the host drives the inverse of the address on the lines, not a stale copy.
  task automatic cycle(input logic [7:0] addr, input logic rd, input logic [7:0] wdata,
                       output logic [7:0] data, output logic oe);
    @(negedge clk_in);
    cs_n_out = 1'h0;
    rw_out = rd;
    ad_out = addr;
    as_out = 1'h1;
    repeat (4) @(negedge clk_in);
    as_out = 1'h0;
    repeat (4) @(negedge clk_in);
    ad_out = rd ? ~addr : wdata;
    ds_out = 1'h1;
    repeat (6) @(negedge clk_in);
    data = rd_data_in;
    oe = rd_oe_in;
    ds_out = 1'h0;
    repeat (5) @(negedge clk_in);
    cs_n_out = 1'h1;
    ad_out = ~ad_out;
  endtask
endmodule // rtcf_host_model
`default_nettype wire

//--- dv/rtcf_event_status_tb.sv
// Testbench for the event status block.
`timescale 1ns/100ps
`default_nettype none
module rtcf_event_status_tb;
  logic       REF_CLK_IN = 1'h0;
  logic       RST_IN = 1'h1;
  logic       valid = 1'h1;
  logic       inh = 1'h0;
  logic [2:0] ev = 3'h0;
  logic [2:0] en = 3'h0;
  logic [7:0] ad, ad_o, d;
  logic       as_s, ds_s, rw_s, cs_n, oe, oe_o, en_o, irq_n;
  int         failures = 0;
  int         total_checks = 0;
  int         tnum = 0;
  always #2.5 REF_CLK_IN = ~REF_CLK_IN;
  rtcf_event_status uut (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .AD_IN(ad), .AD_OUT(ad_o),
    .AD_OE_OUT(oe_o), .AS_IN(as_s), .DS_IN(ds_s), .RW_IN(rw_s), .CS_N_IN(cs_n), .BACKUP_VALID_IN(valid),
    .UPDATE_DONE_IN(ev[0]), .ALARM_HIT_IN(ev[1]), .PERIODIC_TICK_IN(ev[2]), .ALARM_IRQ_ENABLE_IN(en[1]),
    .PERIODIC_IRQ_ENABLE_IN(en[2]), .UPDATE_IRQ_ENABLE_IN(en[0]), .TRANSFER_INHIBIT_IN(inh),
    .UPDATE_IRQ_ENABLE_OUT(en_o), .IRQ_N_OUT(irq_n));
  rtcf_host_model host (.clk_in(REF_CLK_IN), .rd_data_in(ad_o), .rd_oe_in(oe_o), .ad_out(ad),
    .as_out(as_s), .ds_out(ds_s), .rw_out(rw_s), .cs_n_out(cs_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    host.cycle(addr, 1'h1, 8'h00, d, oe);
    cmp_bit(oe, 1'h1);
    cmp_byte(d, exp);
  endtask
  task automatic pulse(input int i);
    @(negedge REF_CLK_IN);
    ev[i] = 1'h1;
    @(negedge REF_CLK_IN);
    ev = 3'h0;
  endtask
  task automatic tend;
    tnum++;
    $display("test %0d finished", tnum);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20us;
    failures++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge REF_CLK_IN);
    RST_IN = 1'h0;
    repeat (4) @(negedge REF_CLK_IN);
    rd(8'h0c, 8'h00);
    rd(8'h0d, 8'h80);
    valid = 1'h0;
    rd(8'h0d, 8'h00);
    host.cycle(8'h0b, 1'h1, 8'h00, d, oe);
    cmp_bit(oe, 1'h0);
    tend();
    for (int i = 0; i < 3; i++) begin
      en = 3'h1 << i;
      pulse(i);
      cmp_bit(irq_n, 1'h0);
      rd(8'h0c, 8'h80 | (8'h10 << i));
      cmp_bit(irq_n, 1'h1);
      rd(8'h0c, 8'h00);
    end
    tend();
    en = 3'h0;
    for (int i = 0; i < 3; i++) pulse(i);
    cmp_bit(irq_n, 1'h1);
    en = 3'h2;
    repeat (2) @(negedge REF_CLK_IN);
    cmp_bit(irq_n, 1'h0);
    rd(8'h0c, 8'hf0);
    pulse(1);
    host.cycle(8'h0c, 1'h0, 8'h00, d, oe);
    cmp_bit(irq_n, 1'h0);
    rd(8'h0c, 8'ha0);
    tend();
    en = 3'h1;
    inh = 1'h1;
    @(negedge REF_CLK_IN);
    cmp_bit(en_o, 1'h0);
    pulse(0);
    cmp_bit(irq_n, 1'h1);
    inh = 1'h0;
    repeat (2) @(negedge REF_CLK_IN);
    cmp_bit(en_o, 1'h1);
    cmp_bit(irq_n, 1'h0);
    rd(8'h0c, 8'h90);
    tend();
    en = 3'h2;
    pulse(1);
    cmp_bit(irq_n, 1'h0);
    @(negedge REF_CLK_IN);
    RST_IN = 1'h1;
    repeat (2) @(negedge REF_CLK_IN);
    cmp_bit(irq_n, 1'h1);
    RST_IN = 1'h0;
    repeat (4) @(negedge REF_CLK_IN);
    rd(8'h0c, 8'h00);
    rd(8'h0d, 8'h00);
    tend();
    final_report();
  end
endmodule // rtcf_event_status_tb
`default_nettype wire
